/* dplc_map.vh */
`ifndef DPLC_MAP_VH
`define DPLC_MAP_VH
// Register offsets of the controller's own register port
`define DPLC_REG_CTRL 4'h0
`define DPLC_REG_DATA 4'h1
`define DPLC_REG_STAT 4'h2
`define DPLC_REG_CMD 4'h3
// Control register fields
`define DPLC_CTRL_SLEEP 0
`define DPLC_CTRL_BYTE_MODE 1
`define DPLC_CTRL_AUTO_XFER 2
// Data register fields
`define DPLC_DATA_CODE_HI 11
`define DPLC_DATA_GAIN 14
`define DPLC_DATA_REFBUF 15
// Command register fields
`define DPLC_CMD_WRITE 0
`define DPLC_CMD_XFER 1
`define DPLC_CMD_WIPE 2
// Status register fields
`define DPLC_STAT_BUSY 0
`define DPLC_STAT_AWAKE 1
`define DPLC_STAT_PENDING 2
// Reset values
`define DPLC_CTRL_RST 3'h0
// Timing in nanoseconds and the system clock period
`define DPLC_CLK_NS 10
`define DPLC_SETUP_NS 20
`define DPLC_STROBE_NS 30
`define DPLC_WAKE_NS 5000
`define DPLC_SETUP_CYC ((`DPLC_SETUP_NS + `DPLC_CLK_NS - 1) / `DPLC_CLK_NS)
`define DPLC_STROBE_CYC ((`DPLC_STROBE_NS + `DPLC_CLK_NS - 1) / `DPLC_CLK_NS)
`define DPLC_WAKE_CYC ((`DPLC_WAKE_NS + `DPLC_CLK_NS - 1) / `DPLC_CLK_NS)
`endif

/* dplc_timer.v */
`include "dplc_map.vh"
// Down counter: loads a count, pulses o_done when it runs out
module dplc_timer #(
  parameter W = 10
) (
  input wire i_clk_sys,
  input wire i_sys_rst,
  input wire i_load,
  input wire [W-1:0] i_count,
  output wire o_busy,
  output wire o_done
);
  reg [W-1:0] cnt_r;
  reg run_r;

  // Count down after a load; a load restarts the count
  always @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      cnt_r <= {W{1'b0}};
      run_r <= 1'b0;
    end else if (i_load) begin
      cnt_r <= i_count;
      run_r <= 1'b1;
    end else if (run_r) begin
      if (cnt_r <= {{(W-1){1'b0}}, 1'b1}) begin
        run_r <= 1'b0;
      end
      cnt_r <= cnt_r - {{(W-1){1'b0}}, 1'b1};
    end
  end

  assign o_busy = run_r;
  assign o_done = run_r && (cnt_r <= {{(W-1){1'b0}}, 1'b1}) && !i_load;
endmodule // dplc_timer

/* dplc_ctrl.v */
// Behaviour
// - Sleep pin low powers the device down; high runs it.
// - Select low and store strobe rising loads input register; transfer low also.
// - Byte select at store rising edge picks low or high byte register.
// - Word bus puts code in low bits, buffer bit15, gain bit14.
// - Byte bus: low byte first with select zero, then high byte.
//
// The register offsets and the strobed register port were decided locally.
`include "dplc_map.vh"
module dplc_ctrl #(
  parameter CODE_W = 12,
  parameter WAKE_CYC = `DPLC_WAKE_CYC
) (
  input wire i_clk_sys,
  input wire i_sys_rst,
  input wire [3:0] i_addr,
  input wire [15:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  output reg [15:0] o_rdata,
  output reg [15:0] o_dac_data,
  output reg o_select_n,
  output reg o_store_strobe_n,
  output reg o_transfer_strobe_n,
  output reg o_async_wipe_n,
  output reg o_upper_byte_sel,
  output reg o_sleep_n
);
  localparam [6:0] S_IDLE = 7'h01;
  localparam [6:0] S_SETUP = 7'h02;
  localparam [6:0] S_STROBE = 7'h04;
  localparam [6:0] S_HOLD = 7'h08;
  localparam [6:0] S_XFER = 7'h10;
  localparam [6:0] S_WIPE = 7'h20;
  localparam [6:0] S_NEXT = 7'h40;
  localparam integer SETUP_I = `DPLC_SETUP_CYC;
  localparam integer STROBE_I = `DPLC_STROBE_CYC;
  localparam integer WAKE_I = WAKE_CYC;
  // Counts cut to the timer width on purpose
  localparam [15:0] SETUP_C = SETUP_I[15:0];
  localparam [15:0] STROBE_C = STROBE_I[15:0];
  localparam [15:0] WAKE_C = WAKE_I[15:0];

  reg [6:0] state_r;
  reg [2:0] ctrl_r;
  reg [15:0] data_r;
  reg want_xfer_r;
  reg second_r;
  reg pending_r;
  reg awake_r;
  reg tload;
  reg [15:0] tcount;
  wire tdone;
  wire wake_done;
  reg sleep_d_r;
  wire cmd_wr;

  // Selects the pin word for the low or high byte of a byte-wide load
  function [15:0] pin_word;
    input [15:0] d;
    input byte_mode;
    input hi;
    begin
      if (!byte_mode) begin
        pin_word = d;
      end else if (hi) begin
        pin_word = {8'h00, d[15], d[14], 2'h0, d[11:8]};
      end else begin
        pin_word = {8'h00, d[7:0]};
      end
    end
  endfunction

  dplc_timer #(.W(16)) u_step (
    .i_clk_sys(i_clk_sys),
    .i_sys_rst(i_sys_rst),
    .i_load(tload),
    .i_count(tcount),
    .o_busy(),
    .o_done(tdone)
  );

  // Wake-up wait after raising the sleep pin
  dplc_timer #(.W(16)) u_wake (
    .i_clk_sys(i_clk_sys),
    .i_sys_rst(i_sys_rst),
    .i_load(o_sleep_n && !sleep_d_r),
    .i_count(WAKE_C),
    .o_busy(),
    .o_done(wake_done)
  );

  assign cmd_wr = i_wr && (i_addr == `DPLC_REG_CMD) && (state_r == S_IDLE);

  // Register port writes and reads
  always @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      ctrl_r <= `DPLC_CTRL_RST;
      data_r <= 16'h0000;
      o_rdata <= 16'h0000;
    end else begin
      if (i_wr && i_addr == `DPLC_REG_CTRL) begin
        ctrl_r <= i_wdata[2:0];
      end
      if (i_wr && i_addr == `DPLC_REG_DATA) begin
        data_r <= i_wdata;
      end
      o_rdata <= 16'h0000;
      if (i_rd) begin
        case (i_addr)
          `DPLC_REG_CTRL: o_rdata <= {13'h0000, ctrl_r};
          `DPLC_REG_DATA: o_rdata <= data_r;
          `DPLC_REG_STAT: o_rdata <= {13'h0000, pending_r, awake_r, state_r != S_IDLE};
          default: o_rdata <= 16'h0000;
        endcase
      end
    end
  end

  // Sleep pin and awake status
  always @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_sleep_n <= 1'b1;
      sleep_d_r <= 1'b1;
      awake_r <= 1'b1;
    end else begin
      o_sleep_n <= ~ctrl_r[`DPLC_CTRL_SLEEP];
      sleep_d_r <= o_sleep_n;
      if (!o_sleep_n) begin
        awake_r <= 1'b0;
      end else if (wake_done) begin
        awake_r <= 1'b1;
      end
    end
  end

  // Pin sequencer: setup, strobe low, rising edge, optional transfer
  always @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state_r <= S_IDLE;
      o_dac_data <= 16'h0000;
      o_select_n <= 1'b1;
      o_store_strobe_n <= 1'b1;
      o_transfer_strobe_n <= 1'b1;
      o_async_wipe_n <= 1'b1;
      o_upper_byte_sel <= 1'b0;
      want_xfer_r <= 1'b0;
      second_r <= 1'b0;
      pending_r <= 1'b0;
      tload <= 1'b0;
      tcount <= 16'h0000;
    end else begin
      tload <= 1'b0;
      case (state_r)
        S_IDLE: begin
          if (cmd_wr && i_wdata[`DPLC_CMD_WIPE]) begin
            o_async_wipe_n <= 1'b0;
            pending_r <= 1'b0;
            tload <= 1'b1;
            tcount <= STROBE_C;
            state_r <= S_WIPE;
          end else if (cmd_wr && i_wdata[`DPLC_CMD_WRITE]) begin
            want_xfer_r <= i_wdata[`DPLC_CMD_XFER] || ctrl_r[`DPLC_CTRL_AUTO_XFER];
            second_r <= 1'b0;
            o_upper_byte_sel <= 1'b0;
            o_dac_data <= pin_word(data_r, ctrl_r[`DPLC_CTRL_BYTE_MODE], 1'b0);
            o_select_n <= 1'b0;
            tload <= 1'b1;
            tcount <= SETUP_C;
            state_r <= S_SETUP;
          end else if (cmd_wr && i_wdata[`DPLC_CMD_XFER] && pending_r) begin
            o_transfer_strobe_n <= 1'b0;
            tload <= 1'b1;
            tcount <= STROBE_C;
            state_r <= S_XFER;
          end
        end
        S_SETUP: if (tdone) begin
          o_store_strobe_n <= 1'b0;
          // Byte mode never transfers with a store, so half a word never reaches the output
          if (want_xfer_r && !ctrl_r[`DPLC_CTRL_BYTE_MODE]) begin
            o_transfer_strobe_n <= 1'b0;
          end
          tload <= 1'b1;
          tcount <= STROBE_C;
          state_r <= S_STROBE;
        end
        S_STROBE: if (tdone) begin
          o_store_strobe_n <= 1'b1;
          pending_r <= !(o_transfer_strobe_n == 1'b0);
          tload <= 1'b1;
          tcount <= SETUP_C;
          state_r <= S_HOLD;
        end
        S_HOLD: if (tdone) begin
          o_select_n <= 1'b1;
          if (ctrl_r[`DPLC_CTRL_BYTE_MODE] && !second_r) begin
            o_transfer_strobe_n <= 1'b1;
            state_r <= S_NEXT;
          end else if (ctrl_r[`DPLC_CTRL_BYTE_MODE] && want_xfer_r) begin
            o_transfer_strobe_n <= 1'b0; // whole word assembled first
            tload <= 1'b1;
            tcount <= STROBE_C;
            state_r <= S_XFER;
          end else begin
            o_transfer_strobe_n <= 1'b1;
            state_r <= S_IDLE;
          end
        end
        S_NEXT: begin
          second_r <= 1'b1;
          o_upper_byte_sel <= 1'b1;
          o_dac_data <= pin_word(data_r, 1'b1, 1'b1);
          o_select_n <= 1'b0;
          tload <= 1'b1;
          tcount <= SETUP_C;
          state_r <= S_SETUP;
        end
        S_XFER: if (tdone) begin
          o_transfer_strobe_n <= 1'b1;
          pending_r <= 1'b0;
          state_r <= S_IDLE;
        end
        S_WIPE: if (tdone) begin
          o_async_wipe_n <= 1'b1;
          state_r <= S_IDLE;
        end
        default: state_r <= S_IDLE;
      endcase
    end
  end
endmodule // dplc_ctrl

/* dplc_ctrl_monitor.sv */
module dplc_ctrl_monitor (
  input wire i_clk_sys,
  input wire i_sys_rst,
  input wire [3:0] i_addr,
  input wire [15:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  input wire [15:0] o_rdata,
  input wire [15:0] o_dac_data,
  input wire o_select_n,
  input wire o_store_strobe_n,
  input wire o_transfer_strobe_n,
  input wire o_async_wipe_n,
  input wire o_upper_byte_sel,
  input wire o_sleep_n
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_sys_rst);
  // Low for exactly four cycles: the strobe count plus the timer's load cycle
  sequence low4_s(s);
    !s [*4] ##1 s;
  endsequence
  store_width_a: assert property ($fell(o_store_strobe_n) |-> low4_s(o_store_strobe_n))
    else $error("store strobe width");
  wipe_width_a: assert property ($fell(o_async_wipe_n) |-> low4_s(o_async_wipe_n))
    else $error("wipe width");
  store_sel_a: assert property (!o_store_strobe_n |-> !o_select_n)
    else $error("store without select");
  pins_stable_a: assert property (!o_store_strobe_n |-> $stable({o_dac_data, o_upper_byte_sel}))
    else $error("pins moved in strobe");
  sel_release_a: assert property ($rose(o_store_strobe_n) |-> ##[1:12] o_select_n)
    else $error("select held");
  xfer_wipe_a: assert property (!o_transfer_strobe_n |-> o_async_wipe_n)
    else $error("transfer during wipe");
  // Control register lands one edge after the write, the pin one edge later
  sleep_follow_a: assert property (i_wr && i_addr == 4'h0 |=> ##1
    o_sleep_n == !$past(i_wdata[0], 2))
    else $error("sleep pin lag");
  rdata_idle_a: assert property (!$past(i_rd) || $past(i_addr) > 4'h3 |-> o_rdata == 16'h0)
    else $error("read data not zero");
endmodule // dplc_ctrl_monitor
bind dplc_ctrl dplc_ctrl_monitor dplc_ctrl_monitor_inst (.i_clk_sys, .i_sys_rst, .i_addr,
  .i_wdata, .i_wr, .i_rd, .o_rdata, .o_dac_data, .o_select_n, .o_store_strobe_n,
  .o_transfer_strobe_n, .o_async_wipe_n, .o_upper_byte_sel, .o_sleep_n);

/* dplc_dev_model.sv */
module dplc_dev_model (
  input wire i_byte_mode,
  input wire [15:0] i_pins,
  input wire i_select_n,
  input wire i_store_n,
  input wire i_xfer_n,
  input wire i_wipe_n,
  input wire i_upper,
  input wire i_sleep_n,
  output logic [11:0] o_in_code,
  output logic [11:0] o_dac_code,
  output logic o_gain,
  output logic o_refbuf,
  output wire o_hiz
);
  timeunit 1ns;
  timeprecision 1ps;
  logic in_gain, in_buf, pend, store_q = 1'b1;
  // Power-on state: all zero, gain one, unbuffered
  initial {o_in_code, o_dac_code, o_gain, o_refbuf, in_gain, in_buf, pend} = '0;
  // Output floats while asleep; registers untouched
  assign o_hiz = !i_sleep_n;
  // Pin events drive the double-buffered registers
  always @(i_store_n or i_xfer_n or i_wipe_n) begin
    if (!i_wipe_n) begin
      {o_in_code, o_dac_code, o_gain, o_refbuf, in_gain, in_buf, pend} = '0;
    end else begin
      if (i_store_n && !store_q && !i_select_n) begin
        if (!i_byte_mode) o_in_code = i_pins[11:0];
        else if (i_upper) o_in_code[11:8] = i_pins[3:0];
        else o_in_code[7:0] = i_pins[7:0];
        {in_buf, in_gain} = i_byte_mode ? i_pins[7:6] : i_pins[15:14];
        pend = 1'b1;
      end
      if (!i_xfer_n && pend) begin
        {o_dac_code, o_gain, o_refbuf} = {o_in_code, in_gain, in_buf};
        pend = 1'b0;
      end
    end
    store_q = i_store_n;
  end
endmodule // dplc_dev_model

/* dac_parallel_load_control_bench.sv */
module dac_parallel_load_control_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk_sys = 0, i_sys_rst = 1, i_wr = 0, i_rd = 0, byte_mode = 0;
  logic [3:0] i_addr = 4'h0;
  logic [15:0] i_wdata = 16'h0, o_rdata, o_dac_data, v;
  logic o_select_n, o_store_strobe_n, o_transfer_strobe_n, o_async_wipe_n;
  logic o_upper_byte_sel, o_sleep_n, gain, refbuf, hiz;
  logic [11:0] in_code, dac_code;
  int mismatches = 0, cmp_count = 0;
  always #5 i_clk_sys = ~i_clk_sys;
  dplc_ctrl #(.WAKE_CYC(4)) dplc_ctrl_inst (.i_clk_sys, .i_sys_rst, .i_addr, .i_wdata, .i_wr,
    .i_rd, .o_rdata, .o_dac_data, .o_select_n, .o_store_strobe_n, .o_transfer_strobe_n,
    .o_async_wipe_n, .o_upper_byte_sel, .o_sleep_n);
  dplc_dev_model dplc_dev_model_inst (.i_byte_mode(byte_mode), .i_pins(o_dac_data),
    .i_select_n(o_select_n), .i_store_n(o_store_strobe_n), .i_xfer_n(o_transfer_strobe_n),
    .i_wipe_n(o_async_wipe_n), .i_upper(o_upper_byte_sel), .i_sleep_n(o_sleep_n),
    .o_in_code(in_code), .o_dac_code(dac_code), .o_gain(gain), .o_refbuf(refbuf), .o_hiz(hiz));
  // Register port cycles
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge i_clk_sys);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk_sys);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge i_clk_sys);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk_sys);
    i_rd <= 1'b0;
    #1 v = o_rdata;
  endtask
  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    cmp_count++;
    if (s !== e) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  // Poll a status bit until it reaches a value, bounded
  task automatic poll(input int b, input logic x);
    for (int k = 0; k < 40; k++) begin
      rd(4'h2);
      if (v[b] === x) break;
    end
    chk("status", {15'h0, v[b]}, {15'h0, x});
  endtask
  task automatic end_of_test();
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (6) @(posedge i_clk_sys);
    i_sys_rst <= 1'b0;
    #1 chk("power on", {gain, refbuf, hiz, 1'b0, dac_code}, 16'h0);
    wr(4'h1, 16'h8abc);
    rd(4'h1);
    chk("data reg", v, 16'h8abc);
    wr(4'h3, 16'h0001);
    poll(0, 1'b0);
    chk("input", {4'h0, in_code}, 16'h0abc);
    chk("held", {4'h0, dac_code}, 16'h0);
    rd(4'h2);
    chk("pending", {15'h0, v[2]}, 16'h1);
    wr(4'h3, 16'h0002);
    poll(0, 1'b0);
    chk("xfer", {gain, refbuf, 2'h0, dac_code}, 16'h4abc);
    wr(4'h1, 16'h4123);
    wr(4'h3, 16'h0003);
    poll(0, 1'b0);
    chk("sync", {gain, refbuf, 2'h0, dac_code}, 16'h8123);
    // Nothing pending: a transfer-only command is refused and the block stays idle
    wr(4'h3, 16'h0002);
    rd(4'h2);
    chk("no pending", v, 16'h0002);
    byte_mode = 1'b1;
    // Byte mode with automatic transfer
    wr(4'h0, 16'h0006);
    wr(4'h1, 16'hc5a7);
    wr(4'h3, 16'h0001);
    poll(0, 1'b0);
    chk("bytes", {gain, refbuf, 2'h0, dac_code}, 16'hc5a7);
    wr(4'h0, 16'h0001);
    repeat (2) @(posedge i_clk_sys);
    #1 chk("asleep", {3'h0, hiz, dac_code}, 16'h15a7);
    wr(4'h0, 16'h0000);
    rd(4'h2);
    chk("waking", {15'h0, v[1]}, 16'h0);
    poll(1, 1'b1);
    chk("awake", {3'h0, hiz, dac_code}, 16'h05a7);
    wr(4'h3, 16'h0004);
    poll(0, 1'b0);
    chk("wipe", {4'h0, in_code | dac_code}, 16'h0);
    rd(4'hf);
    chk("unmapped", v, 16'h0);
    end_of_test();
  end
  initial begin
    #100us;
    mismatches++;
    end_of_test();
  end
endmodule // dac_parallel_load_control_bench
